//--- rtl/dacrb_pkg.sv
/*
  Shared constants and types for the dual-channel DAC serial command decoder
  and its readback path.
  Assumes one system clock; all pins are synchronised before use.
*/
package dacrb_pkg;

  // Frame layout: one header byte, then the 24-bit data field.
  localparam int unsigned FRAME_BITS   = 32;
  localparam int unsigned HDR_BITS     = 8;
  localparam int unsigned DATA_BITS    = 24;
  localparam int unsigned CODE_BITS    = 18;
  localparam int unsigned SPAN_BITS    = 4;

  // Field positions inside the 32-bit frame word.
  localparam int unsigned CMD_MSB      = 31;
  localparam int unsigned ADDR_MSB     = 27;
  localparam int unsigned CODE_LSB     = 6;
  localparam int unsigned SPAN_LSB     = 8;

  // Command codes.
  localparam logic [3:0] CMD_WR_SPAN       = 4'h2;
  localparam logic [3:0] CMD_WR_CODE       = 4'h3;
  localparam logic [3:0] CMD_UPD_N         = 4'h4;
  localparam logic [3:0] CMD_UPD_ALL       = 4'h5;
  localparam logic [3:0] CMD_WR_SPAN_UPD_N = 4'h6;
  localparam logic [3:0] CMD_WR_CODE_UPD_N = 4'h7;
  localparam logic [3:0] CMD_WR_SPAN_UPD_A = 4'h8;
  localparam logic [3:0] CMD_WR_CODE_UPD_A = 4'h9;
  localparam logic [3:0] CMD_RD_IN_SPAN    = 4'hA;
  localparam logic [3:0] CMD_RD_IN_CODE    = 4'hB;
  localparam logic [3:0] CMD_RD_DAC_SPAN   = 4'hC;
  localparam logic [3:0] CMD_RD_DAC_CODE   = 4'hD;
  localparam logic [3:0] CMD_NOP           = 4'hF;

  // Channel address codes, lowest address bit ignored.
  localparam logic [2:0] ADDR_CH_A   = 3'h0;
  localparam logic [2:0] ADDR_CH_B   = 3'h1;
  localparam logic [2:0] ADDR_CH_ALL = 3'h7;

  // Synchroniser bit positions and reset values.
  localparam int unsigned SYNC_W     = 9;
  localparam int unsigned SY_SCLK    = 0;
  localparam int unsigned SY_CSN     = 1;
  localparam int unsigned SY_SDI     = 2;
  localparam int unsigned SY_UPDN    = 3;
  localparam int unsigned SY_CLRN    = 4;
  localparam int unsigned SY_MSPAN   = 5;
  localparam int unsigned SY_RANGE0  = 6;
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h01A;

  // Reset values.
  localparam logic [CODE_BITS-1:0] CODE_RST = 18'h00000;
  localparam logic [SPAN_BITS-1:0] SPAN_RST = 4'h0;

  // Register chosen for readback.
  typedef enum logic [1:0] {
    DACRB_SEL_IN_SPAN  = 2'b00,
    DACRB_SEL_IN_CODE  = 2'b01,
    DACRB_SEL_DAC_SPAN = 2'b10,
    DACRB_SEL_DAC_CODE = 2'b11
  } dacrb_sel_t;

  // Readback pointer: register kind and channel (0 = A, 1 = B).
  typedef struct packed {
    dacrb_sel_t sel;
    logic       chan;
  } dacrb_ptr_t;

  localparam dacrb_ptr_t PTR_RST = '{sel: DACRB_SEL_DAC_SPAN, chan: 1'b0};

  // Register set of one channel.
  typedef struct packed {
    logic [CODE_BITS-1:0] in_code;
    logic [SPAN_BITS-1:0] in_span;
    logic [CODE_BITS-1:0] dac_code;
    logic [SPAN_BITS-1:0] dac_span;
  } dacrb_chan_t;

  // Frame receiver states.
  typedef enum logic [1:0] {
    DACRB_FR_IDLE  = 2'b00,
    DACRB_FR_HDR   = 2'b01,
    DACRB_FR_DATA  = 2'b10,
    DACRB_FR_ABORT = 2'b11
  } dacrb_frame_t;

endpackage : dacrb_pkg

//--- rtl/dacrb_sync.sv
/*
  Two-flop synchroniser for a group of pin inputs.
  Assumes each bit is an independent level; the first flop feeds only the second.
*/
`timescale 1ns/1ps
`default_nettype none

module dacrb_sync
  #(
    parameter int unsigned       WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
  )
  (
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
  );

  logic [WIDTH-1:0] meta_reg;

  // Two flops in series; reset to the idle pin levels.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end

endmodule : dacrb_sync

`default_nettype wire

//--- rtl/dacrb_chan_regs.sv
/*
  Input and DAC registers (code and span) of one converter channel.
  Assumes write and update strobes are one-cycle pulses on sys_clk; clear is a level held while the pin is low.
*/
`timescale 1ns/1ps
`default_nettype none

module dacrb_chan_regs
  import dacrb_pkg::*;
  (
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire logic                 wr_code,
    input  wire logic                 wr_span,
    input  wire logic [CODE_BITS-1:0] new_code,
    input  wire logic [SPAN_BITS-1:0] new_span,
    input  wire logic                 update,
    input  wire logic                 clear,
    output dacrb_chan_t               regs
  );

  logic [CODE_BITS-1:0] code_src;
  logic [SPAN_BITS-1:0] span_src;

  // A write and an update in one command copy the freshly written value.
  assign code_src = wr_code ? new_code : regs.in_code;
  assign span_src = wr_span ? new_span : regs.in_span;

  // Input registers survive a clear; DAC registers return to zero.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      regs <= '{in_code: CODE_RST, in_span: SPAN_RST, dac_code: CODE_RST, dac_span: SPAN_RST};
    end
    else
    begin
      regs.in_code <= code_src;
      regs.in_span <= span_src;
      if (clear)
      begin
        regs.dac_code <= CODE_RST;
        regs.dac_span <= SPAN_RST;
      end
      else if (update)
      begin
        regs.dac_code <= code_src;
        regs.dac_span <= span_src;
      end
    end
  end

endmodule : dacrb_chan_regs

`default_nettype wire

//--- rtl/dacrb_top.sv
/*
  Serial command decoder with rolling readback for a dual 18-bit DAC.
  Assumes serial clock, strobe, data and strap pins are asynchronous to sys_clk
  and that the serial clock is well below a quarter of the sys_clk rate.
*/
// What this block does
// - Frame is command nibble, address nibble, 24 data bits, MSB first, strobe low.
// - Serial data is sampled on each serial clock rise while strobe is low.
// - Readback drives low after strobe falls; released while strobe is high.
// - Update copies input code and span into the DAC registers.
// - Every frame that completes its header byte without clear copies one chosen register into the readback shifter.
// - Readback fills the data field, first bit on the fall after address.
// - Code readback puts 18 bits first, MSB first, rest zero.
// - Span readback sits in low nibble of second data byte, rest zero.
// - Each output bit is driven on the fall before its matching input rise.
// - Read commands return the requested register in the same frame.
// - Other commands return the pointer set before, then move the pointer.
// - 0010/0011 write input span/code and point at that register.
// - 0100/0101 update one/all; 0110-1001 write then update one/all.
// - Pointer goes to DAC span or DAC code as listed per command.
// - 1010-1101 read input span, input code, DAC span, DAC code.
// - Reset and clear point readback at channel A DAC span.
// - Address bit zero ignored; all-channel reads return channel A.
// - Top span bit is ignored by the span decode.
// - DAC span readback shows straps in manual mode, stored value otherwise.
// - Strap bits appear in the same positions as stored span bits.
// - Input code registers are zero after power-on.
`timescale 1ns/1ps
`default_nettype none

module dacrb_top
  import dacrb_pkg::*;
  (
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire logic                 serial_clk,
    input  wire logic                 select_load_strobe_n,
    input  wire logic                 serial_data_in,
    input  wire logic                 async_update_n,
    input  wire logic                 system_clear_n,
    input  wire logic                 manual_span_mode,
    input  wire logic                 range_bit2,
    input  wire logic                 range_bit1,
    input  wire logic                 range_bit0,
    output logic                      readback_serial_out,
    output logic                      readback_serial_oe,
    output logic      [CODE_BITS-1:0] dac_code_a,
    output logic      [CODE_BITS-1:0] dac_code_b,
    output logic      [SPAN_BITS-1:0] active_span_a,
    output logic      [SPAN_BITS-1:0] active_span_b
  );

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Pointer named by a command; other codes keep the old pointer.
  function automatic dacrb_ptr_t cmd_ptr(input logic [3:0] cmd, input logic [3:0] addr,
                                         input dacrb_ptr_t old);
    dacrb_ptr_t p;
    p      = old;
    p.chan = (addr[3:1] == ADDR_CH_B);
    case (cmd)
      CMD_WR_SPAN, CMD_RD_IN_SPAN:                         p.sel = DACRB_SEL_IN_SPAN;
      CMD_WR_CODE, CMD_RD_IN_CODE:                         p.sel = DACRB_SEL_IN_CODE;
      CMD_UPD_N, CMD_WR_SPAN_UPD_N, CMD_WR_SPAN_UPD_A,
      CMD_RD_DAC_SPAN:                                     p.sel = DACRB_SEL_DAC_SPAN;
      CMD_UPD_ALL, CMD_WR_CODE_UPD_N, CMD_WR_CODE_UPD_A,
      CMD_RD_DAC_CODE, CMD_NOP:                            p.sel = DACRB_SEL_DAC_CODE;
      default:                                             p     = old;
    endcase
    return p;
  endfunction : cmd_ptr

  // Read commands are 1010 through 1101.
  // read command decode
  function automatic logic is_read(input logic [3:0] cmd);
    return (cmd >= CMD_RD_IN_SPAN) && (cmd <= CMD_RD_DAC_CODE);
  endfunction : is_read

  // Span value aligned into the 24-bit data field.
  function automatic logic [DATA_BITS-1:0] span_field(input logic [SPAN_BITS-1:0] s);
    return {12'h000, s, 8'h00};
  endfunction : span_field

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  logic [SYNC_W-1:0] pins_s;
  logic              sclk_d_reg;
  logic              csn_d_reg;
  logic              updn_d_reg;

  dacrb_sync #(.WIDTH(SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pin_in   ({range_bit2, range_bit1, range_bit0, manual_span_mode, system_clear_n,
                async_update_n, serial_data_in, select_load_strobe_n, serial_clk}),
    .sync_out (pins_s)
  );

  wire       sclk_s   = pins_s[SY_SCLK];
  wire       csn_s    = pins_s[SY_CSN];
  wire       sdi_s    = pins_s[SY_SDI];
  wire       clrn_s   = pins_s[SY_CLRN];
  wire       mspan_s  = pins_s[SY_MSPAN];
  wire [2:0] straps_s = {pins_s[SY_RANGE0+2], pins_s[SY_RANGE0+1], pins_s[SY_RANGE0]};

  // Delayed copies of the second synchroniser stage for edge detection.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_d_reg <= 1'b0;
      csn_d_reg  <= 1'b1;
      updn_d_reg <= 1'b1;
    end
    else
    begin
      sclk_d_reg <= sclk_s;
      csn_d_reg  <= csn_s;
      updn_d_reg <= pins_s[SY_UPDN];
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_fall   = ~csn_s & csn_d_reg;
  wire cs_rise   = csn_s & ~csn_d_reg;
  // Asynchronous update is locked out while the strobe is low.
  wire async_update_n_fire = ~pins_s[SY_UPDN] & updn_d_reg & csn_s;

  ////////////////////////////////////////////////////////////////////////////
  // Frame receiver state.

  dacrb_frame_t              state_reg;
  dacrb_frame_t              state_next;
  logic [FRAME_BITS-1:0]     shift_reg;
  logic [5:0]                cnt_reg;
  logic [DATA_BITS-1:0]      rb_shift_reg;
  dacrb_ptr_t                ptr_reg;
  dacrb_chan_t               regs_a;
  dacrb_chan_t               regs_b;

  wire [7:0] hdr_byte  = {shift_reg[6:0], sdi_s};
  wire       hdr_done  = (state_reg == DACRB_FR_HDR) && sclk_rise && (cnt_reg == 6'(HDR_BITS - 1));
  wire       frame_ok  = (state_reg == DACRB_FR_DATA) && cs_rise && (cnt_reg == 6'(FRAME_BITS));
  wire       clr_now   = ~clrn_s;

  // Next state: clear aborts any frame in progress until the strobe rises.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      DACRB_FR_IDLE:  if (cs_fall && !clr_now) state_next = DACRB_FR_HDR;
      DACRB_FR_HDR:   if (cs_rise) state_next = DACRB_FR_IDLE;
                      else if (clr_now) state_next = DACRB_FR_ABORT;
                      else if (hdr_done) state_next = DACRB_FR_DATA;
      DACRB_FR_DATA:  if (cs_rise) state_next = DACRB_FR_IDLE;
                      else if (clr_now) state_next = DACRB_FR_ABORT;
      DACRB_FR_ABORT: if (csn_s) state_next = DACRB_FR_IDLE;
      default:        state_next = DACRB_FR_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      state_reg <= DACRB_FR_IDLE;
    else
      state_reg <= state_next;
  end

  // serial input shifting, MSB first, bit count saturates past a frame.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_reg <= 32'h0000_0000;
      cnt_reg   <= 6'h00;
    end
    else if (cs_fall)
    begin
      cnt_reg <= 6'h00;
    end
    else if (sclk_rise && !csn_s)
    begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], sdi_s};
      if (cnt_reg <= 6'(FRAME_BITS))
        cnt_reg <= cnt_reg + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback source selection.

  // reads pick their own register, others use the stored pointer.
  wire dacrb_ptr_t rb_ptr = is_read(hdr_byte[7:4]) ? cmd_ptr(hdr_byte[7:4], hdr_byte[3:0], ptr_reg)
                                                   : ptr_reg;
  wire dacrb_chan_t rb_ch = rb_ptr.chan ? regs_b : regs_a;

  // span in force: straps in manual mode, same bit positions.
  wire [SPAN_BITS-1:0] rb_dac_span = mspan_s ? {1'b0, straps_s} : rb_ch.dac_span;

  logic [DATA_BITS-1:0] rb_word;

  // data field alignment with zero fill.
  always_comb
  begin
    case (rb_ptr.sel)
      DACRB_SEL_IN_SPAN:  rb_word = span_field(rb_ch.in_span);
      DACRB_SEL_IN_CODE:  rb_word = {rb_ch.in_code, 6'h00};
      DACRB_SEL_DAC_SPAN: rb_word = span_field(rb_dac_span);
      default:            rb_word = {rb_ch.dac_code, 6'h00};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback output pin.

  // load after the address, shift out on each serial clock fall.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rb_shift_reg        <= 24'h000000;
      readback_serial_out <= 1'b0;
    end
    else if (cs_fall || state_reg == DACRB_FR_IDLE || state_reg == DACRB_FR_ABORT)
    begin
      readback_serial_out <= 1'b0;
    end
    else if (hdr_done)
    begin
      rb_shift_reg <= rb_word;
    end
    else if (state_reg == DACRB_FR_DATA && sclk_fall && cnt_reg < 6'(FRAME_BITS))
    begin
      readback_serial_out <= rb_shift_reg[DATA_BITS-1];
      rb_shift_reg        <= {rb_shift_reg[DATA_BITS-2:0], 1'b0};
    end
  end

  // pin released whenever the strobe is high.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      readback_serial_oe <= 1'b0;
    else
      readback_serial_oe <= ~csn_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command execution at the end of a complete frame.

  wire [3:0]           ex_cmd  = shift_reg[CMD_MSB -: 4];
  wire [3:0]           ex_addr = shift_reg[ADDR_MSB -: 4];
  wire [CODE_BITS-1:0] ex_code = shift_reg[CODE_LSB +: CODE_BITS];
  wire [SPAN_BITS-1:0] ex_span = shift_reg[SPAN_LSB +: SPAN_BITS];

  wire sel_a = (ex_addr[3:1] == ADDR_CH_A) || (ex_addr[3:1] == ADDR_CH_ALL);
  wire sel_b = (ex_addr[3:1] == ADDR_CH_B) || (ex_addr[3:1] == ADDR_CH_ALL);

  wire wr_span = frame_ok && (ex_cmd == CMD_WR_SPAN || ex_cmd == CMD_WR_SPAN_UPD_N ||
                              ex_cmd == CMD_WR_SPAN_UPD_A);
  wire wr_code = frame_ok && (ex_cmd == CMD_WR_CODE || ex_cmd == CMD_WR_CODE_UPD_N ||
                              ex_cmd == CMD_WR_CODE_UPD_A);
  wire upd_one = frame_ok && (ex_cmd == CMD_UPD_N || ex_cmd == CMD_WR_SPAN_UPD_N ||
                              ex_cmd == CMD_WR_CODE_UPD_N);
  wire upd_all = (frame_ok && (ex_cmd == CMD_UPD_ALL || ex_cmd == CMD_WR_SPAN_UPD_A ||
                               ex_cmd == CMD_WR_CODE_UPD_A)) || async_update_n_fire;

  dacrb_chan_regs u_chan_a (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .wr_code  (wr_code && sel_a),
    .wr_span  (wr_span && sel_a),
    .new_code (ex_code),
    .new_span (ex_span),
    .update   (upd_all || (upd_one && sel_a)),
    .clear    (clr_now),
    .regs     (regs_a)
  );

  dacrb_chan_regs u_chan_b (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .wr_code  (wr_code && sel_b),
    .wr_span  (wr_span && sel_b),
    .new_code (ex_code),
    .new_span (ex_span),
    .update   (upd_all || (upd_one && sel_b)),
    .clear    (clr_now),
    .regs     (regs_b)
  );

  // pointer moves after each complete frame; clear resets it.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ptr_reg <= PTR_RST;
    else if (clr_now)
      ptr_reg <= PTR_RST;
    else if (frame_ok)
      ptr_reg <= cmd_ptr(ex_cmd, ex_addr, ptr_reg);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel outputs.

  // active span: straps in manual mode, top span bit dropped.
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dac_code_a    <= CODE_RST;
      dac_code_b    <= CODE_RST;
      active_span_a <= SPAN_RST;
      active_span_b <= SPAN_RST;
    end
    else
    begin
      dac_code_a    <= regs_a.dac_code;
      dac_code_b    <= regs_b.dac_code;
      active_span_a <= mspan_s ? {1'b0, straps_s} : {1'b0, regs_a.dac_span[2:0]};
      active_span_b <= mspan_s ? {1'b0, straps_s} : {1'b0, regs_b.dac_span[2:0]};
    end
  end

endmodule : dacrb_top

`default_nettype wire

//--- verification/dacrb_chk.sv
/*
  Pin-level checker for the dual DAC serial decoder with readback.
  Assumes it is bound to dacrb_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none

module dacrb_chk
  import dacrb_pkg::*;
  (
    input wire logic                 sys_clk,
    input wire logic                 arst_n,
    input wire logic                 serial_clk,
    input wire logic                 select_load_strobe_n,
    input wire logic                 system_clear_n,
    input wire logic                 manual_span_mode,
    input wire logic                 range_bit2,
    input wire logic                 range_bit1,
    input wire logic                 range_bit0,
    input wire logic                 readback_serial_out,
    input wire logic                 readback_serial_oe,
    input wire logic [CODE_BITS-1:0] dac_code_a,
    input wire logic [CODE_BITS-1:0] dac_code_b,
    input wire logic [SPAN_BITS-1:0] active_span_a,
    input wire logic [SPAN_BITS-1:0] active_span_b
  );

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // Strap pins seen as a span word; the top bit never comes from a pin.
  wire logic [SPAN_BITS-1:0] strap_span = {1'b0, range_bit2, range_bit1, range_bit0};

  //////////////////////////////////////////////////////////////////////////////
  // Readback pin drive and timing.
  a_oe_idle: assert property (select_load_strobe_n [*6] |-> !readback_serial_oe)
    else $error("readback driven outside a frame");
  a_oe_frame: assert property ((!select_load_strobe_n && system_clear_n) [*6] |-> readback_serial_oe)
    else $error("readback not driven inside a frame");
  a_lead_low: assert property ($rose(readback_serial_oe) |-> !readback_serial_out [*4])
    else $error("readback not low at frame start");
  a_bit_timing: assert property (serial_clk [*2] |=> $stable(readback_serial_out))
    else $error("readback changed while serial clock high");

  //////////////////////////////////////////////////////////////////////////////
  // Register outputs.
  a_span_top: assert property (!active_span_a[3] && !active_span_b[3])
    else $error("span top bit in force");
  a_strap_span: assert property ((manual_span_mode && $stable(strap_span)) [*8]
    |-> active_span_a == strap_span && active_span_b == strap_span)
    else $error("strap span not in force");
  a_clear_zero: assert property (!system_clear_n [*6] |-> dac_code_a == CODE_RST && dac_code_b == CODE_RST)
    else $error("clear left a code");
  a_hold_frame: assert property ((!select_load_strobe_n && system_clear_n) [*5]
    |=> $stable(dac_code_a) && $stable(dac_code_b))
    else $error("code moved inside a frame");

endmodule : dacrb_chk

bind dacrb_top dacrb_chk chk_i (.sys_clk, .arst_n, .serial_clk, .select_load_strobe_n, .system_clear_n,
  .manual_span_mode, .range_bit2, .range_bit1, .range_bit0, .readback_serial_out, .readback_serial_oe,
  .dac_code_a, .dac_code_b, .active_span_a, .active_span_b);

`default_nettype wire

//--- verification/dacrb_host_model.sv
/*
  Serial host model: frames commands and captures readback bits.
  Assumes the bench calls xfer; every pin moves on a falling sys_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module dacrb_host_model
  (
    input  wire logic sys_clk,
    input  wire logic rb_out,
    input  wire logic rb_oe,
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi
  );

  // Readback line as the host sees it; floats when released.
  wire logic rb_line = rb_oe ? rb_out : 1'bz;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////////
  // One frame of n bits; clock low 150 ns, high 50 ns, idle low at strobe edges.
  // framing and sampling
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rb);
    logic [31:0] acc;
    acc = 32'h0;
    @(negedge sys_clk) cs_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    for (int i = 0; i < n; i++)
    begin
      sdi = w[31-i];
      repeat (6) @(negedge sys_clk);
      acc = {acc[30:0], rb_line};
      sclk = 1'b1;
      repeat (2) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (2) @(negedge sys_clk);
    cs_n = 1'b1;
    sdi = ~sdi;  // Released data line does not keep its last value.
    repeat (8) @(negedge sys_clk);
    rb = acc;
  endtask : xfer

endmodule : dacrb_host_model

`default_nettype wire

//--- verification/dual_dac_serial_cmd_readback_test.sv
/*
  Self-checking bench for dacrb_top with the serial host model.
  Assumes a 40 MHz sys_clk; bench inputs move on its falling edge.
*/
`timescale 1ns/1ps
`default_nettype none

module dual_dac_serial_cmd_readback_test;
  import dacrb_pkg::*;

  localparam logic [23:0] CA = {18'h2AAAB, 6'h00};
  localparam logic [23:0] CB = {18'h3FFFF, 6'h00};

  logic                 sys_clk;
  logic                 arst_n;
  logic                 sclk;
  logic                 cs_n;
  logic                 sdi;
  logic                 upd_n;
  logic                 clr_n;
  logic                 mspan;
  logic [2:0]           straps;
  logic                 rb_out;
  logic                 rb_oe;
  logic [CODE_BITS-1:0] code_a;
  logic [CODE_BITS-1:0] code_b;
  logic [SPAN_BITS-1:0] span_a;
  logic [SPAN_BITS-1:0] span_b;
  int                   failures;
  int                   tests_run;

  dacrb_top dut (.sys_clk(sys_clk), .arst_n(arst_n), .serial_clk(sclk), .select_load_strobe_n(cs_n),
    .serial_data_in(sdi), .async_update_n(upd_n), .system_clear_n(clr_n), .manual_span_mode(mspan),
    .range_bit2(straps[2]), .range_bit1(straps[1]), .range_bit0(straps[0]), .readback_serial_out(rb_out),
    .readback_serial_oe(rb_oe), .dac_code_a(code_a), .dac_code_b(code_b), .active_span_a(span_a),
    .active_span_b(span_b));

  dacrb_host_model host (.sys_clk(sys_clk), .rb_out(rb_out), .rb_oe(rb_oe), .sclk(sclk), .cs_n(cs_n), .sdi(sdi));

  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    close_out();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared comparison, frame and verdict tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // A full frame whose header byte must read back low.
  task automatic fr(input logic [31:0] w, input logic [23:0] e);
    logic [31:0] rb;
    host.xfer(w, 32, rb);
    chk(rb, {8'h00, e});
  endtask : fr

  task automatic close_out();
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  //////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  // scenarios send only defined command, address and span codes.
  task automatic t_code_a();
    fr({4'hF, 4'h0, 24'h0}, 24'h0);
    fr({4'hB, 4'h2, 24'h0}, 24'h0);
    fr({4'h3, 4'h1, 18'h2AAAB, 6'h3F}, 24'h0);
    fr({4'hF, 4'h0, 24'h0}, CA);
    fr({4'hB, 4'hF, 24'h0}, CA);
    chk({14'h0, code_a}, 32'h0);
  endtask : t_code_a

  task automatic t_span_b();
    fr({4'h2, 4'h3, 8'h00, 8'h03, 8'h00}, CA);
    fr({4'h4, 4'h2, 24'h0}, 24'h000300);
    chk({28'h0, span_b}, 32'h3);
    fr({4'hF, 4'h0, 24'h0}, 24'h000300);
    fr({4'h9, 4'h2, 18'h3FFFF, 6'h00}, 24'h0);
    fr({4'hF, 4'h0, 24'h0}, CB);
    chk({14'h0, code_a}, {14'h0, 18'h2AAAB});
    chk({14'h0, code_b}, {14'h0, 18'h3FFFF});
  endtask : t_span_b

  task automatic t_short();
    logic [31:0] rb;
    host.xfer({4'h3, 4'h0, 18'h00001, 6'h00}, 31, rb);
    fr({4'hB, 4'h0, 24'h0}, CA);
  endtask : t_short

  task automatic t_manual();
    @(negedge sys_clk) mspan = 1'b1;
    straps = 3'b100;
    repeat (10) @(negedge sys_clk);
    chk({24'h0, span_a, span_b}, 32'h44);
    clr_n = 1'b0;
    repeat (6) @(negedge sys_clk);
    clr_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk({14'h0, code_a}, 32'h0);
    fr({4'hF, 4'h0, 24'h0}, 24'h000400);
    upd_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    upd_n = 1'b1;
    mspan = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk({14'h0, code_a}, {14'h0, 18'h2AAAB});
    chk({24'h0, span_a, span_b}, 32'h03);
    fr({4'h6, 4'h0, 8'h00, 8'h0C, 8'h00}, CA);
    chk({28'h0, span_a}, 32'h4);
  endtask : t_manual

  task automatic t_cmds();
    fr({4'hA, 4'h2, 24'h0}, 24'h000300);
    fr({4'hC, 4'h2, 24'h0}, 24'h000300);
    fr({4'hD, 4'h0, 24'h0}, CA);
    fr({4'h7, 4'h2, 18'h00010, 6'h00}, CA);
    fr({4'h5, 4'h0, 24'h0}, {18'h00010, 6'h00});
    fr({4'h8, 4'h2, 8'h00, 8'h01, 8'h00}, CA);
    fr({4'hF, 4'h0, 24'h0}, 24'h000100);
    chk({24'h0, span_a, span_b}, 32'h41);
  endtask : t_cmds

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, then every scenario in turn.
  initial
  begin
    failures = 0;
    tests_run = 0;
    arst_n = 1'b0;
    upd_n = 1'b1;
    clr_n = 1'b1;
    mspan = 1'b0;
    straps = 3'b000;
    repeat (10) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (6) @(negedge sys_clk);
    t_code_a();
    t_span_b();
    t_short();
    t_manual();
    t_cmds();
    close_out();
  end

endmodule : dual_dac_serial_cmd_readback_test

`default_nettype wire
